// *** hw/psfl_sequencer.sv ***
// Power sequencing and fault supervision for four regulated outputs
// Summary of operation
// - no soft-start until bias, 5V and 3.3V monitors all good, then start automatically
// - chipset linear control runs independent of power-on reset, kept near 3.3V rail
// - bus soft-start steps to about 1V then ramps to about 4.5V
// - core soft-start held at zero until bus output passes 90% good level
// - core switcher gives no pulse until core soft-start reaches 1.25V valley
// - bus good goes high on first core pulse if bus output stays above 1.08V
// - system good only when every output is within its limits
// - core soft-start clamps AGP reference, bus soft-start clamps chipset reference
// - core overvoltage disables outputs one to three and latches off
// - unblanked chipset undervoltage latches off at once, no retry
// - overcurrent or AGP undervoltage counts, shuts outputs, restarts via soft-start
// - either counter at three consecutive events sets the fault latch
// - counters clear on successful start-up; all clears only when bias goes away
// - each soft-start node has a charged flag above 4.0V
// - linear undervoltage ignored until its soft-start charged flag is true
// - unblanked AGP undervoltage sets overcurrent latch, chipset sets fault latch
// - on overcurrent inhibit outputs, slow-discharge bus node, fast-discharge core node
// - recurrence during retry lets node pass 4.0V before discharging, counts
// - bus node below 0.8V after overcurrent clears latch and restarts outputs
// - overcurrent accepted only while its upper switch drive is active
// - bias below reset but above 4V: core lower switch on if sense over 1.3V
// - bus good low while bus undervoltage or core soft-start below 1.25V
// - external pull of bus node below 0.8V forces reset and shutdown
`timescale 1ns/1ps
`include "psfl_defs.svh"
module psfl_sequencer #(
  parameter int RAMP_DIV = `PSFL_RAMP_DIV
) (
  input  wire logic                  clk,           // 50 MHz oscillator clock
  input  wire logic                  nrst,          // Async reset, active low
  input  wire psfl_pkg::psfl_supply_t supply_in,    // Supply monitor comparators
  input  wire psfl_pkg::psfl_sense_t  sense_in,     // Output sense comparators
  input  wire psfl_pkg::psfl_switch_t switch_in,    // Overcurrent and drive status
  input  wire logic                  bus_node_low,  // Bus soft-start node under 0.8V
  output logic                       core_en,       // Core switcher enable
  output logic                       bus_en,        // Bus switcher enable
  output logic                       agp_en,        // AGP linear enable
  output logic                       chipset_en,    // Chipset linear enable
  output logic                       core_lower_on, // Force core lower switch on
  output logic                       bus_ss_fast,   // Fast step of bus soft-start node
  output logic                       bus_ss_dis,    // Bus node 28uA discharge
  output logic                       core_ss_dis,   // Core node rapid discharge
  output logic [`PSFL_SS_W-1:0]      bus_ss_level,  // Bus node level, chipset ref clamp
  output logic [`PSFL_SS_W-1:0]      core_ss_level, // Core node level, AGP ref clamp
  output logic                       bus_supply_good_out,    // Bus power good
  output logic                       system_supply_good_out, // System power good
  output logic                       fault_latched  // Latch-off status
);
  localparam int SYNC_W = $bits(psfl_pkg::psfl_supply_t) + $bits(psfl_pkg::psfl_sense_t)
                          + $bits(psfl_pkg::psfl_switch_t) + 1;

  logic [SYNC_W-1:0]        sync1_r;
  logic [SYNC_W-1:0]        sync2_r;
  psfl_pkg::psfl_supply_t   sup;
  psfl_pkg::psfl_sense_t    sns;
  psfl_pkg::psfl_switch_t   sw;
  logic                     node_low;
  psfl_pkg::psfl_state_t    state_r;
  logic [`PSFL_SS_W-1:0]    bus_ss_r;
  logic [`PSFL_SS_W-1:0]    core_ss_r;
  logic [15:0]              div_r;
  logic                     tick;
  logic [`PSFL_CNT_W-1:0]   core_cnt_r;
  logic [`PSFL_CNT_W-1:0]   bus_cnt_r;
  logic                     oc_latch_r;
  logic                     fault_r;
  logic                     oc_pend_r;
  logic                     bus_up;
  logic                     core_up;
  logic                     por_ok;
  logic                     core_oc_q;
  logic                     bus_oc_q;
  logic                     agp_uv_q;
  logic                     chip_uv_q;
  logic                     oc_event;
  logic                     vtt_good_r;

  // Two flops on every analog comparator result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {supply_in, sense_in, switch_in, bus_node_low};
      sync2_r <= sync1_r;
    end
  end
  assign {sup, sns, sw, node_low} = sync2_r;

  // Ramp rate enable; one tick per divider period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (div_r == 16'(RAMP_DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign tick = (div_r == 16'(RAMP_DIV - 1));

  assign por_ok   = sup.bias_ok && sup.five_ok && sup.aux_ok && !node_low;
  assign bus_up   = (bus_ss_r > `PSFL_SS_UP_4V);
  assign core_up  = (core_ss_r > `PSFL_SS_UP_4V);
  assign core_oc_q = sw.core_oc && sw.core_hi_drive;
  assign bus_oc_q  = sw.bus_oc && sw.bus_hi_drive;
  assign agp_uv_q  = sns.agp_uv && core_up;
  assign chip_uv_q = sns.chipset_uv && bus_up;
  assign oc_event  = core_oc_q || bus_oc_q || agp_uv_q;

  // Sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= psfl_pkg::PSFL_OFF;
    end else if (!sup.bias_ok) begin
      state_r <= psfl_pkg::PSFL_OFF;
    end else begin
      case (state_r)
        psfl_pkg::PSFL_OFF: begin
          if (fault_r) state_r <= psfl_pkg::PSFL_LATCHED;
          else if (por_ok) state_r <= psfl_pkg::PSFL_BUS_RMP;
        end
        psfl_pkg::PSFL_BUS_RMP, psfl_pkg::PSFL_CORE_RMP, psfl_pkg::PSFL_RUN: begin
          if (fault_r) state_r <= psfl_pkg::PSFL_LATCHED;
          else if (!por_ok) state_r <= psfl_pkg::PSFL_OFF;
          else if (oc_latch_r) state_r <= psfl_pkg::PSFL_RETRY;
          else if (state_r == psfl_pkg::PSFL_BUS_RMP && sns.bus_pg90) state_r <= psfl_pkg::PSFL_CORE_RMP;
          else if (state_r == psfl_pkg::PSFL_CORE_RMP && bus_up && core_up) state_r <= psfl_pkg::PSFL_RUN;
        end
        psfl_pkg::PSFL_RETRY: begin
          if (fault_r) state_r <= psfl_pkg::PSFL_LATCHED;
          else if (!oc_latch_r) state_r <= psfl_pkg::PSFL_OFF;
        end
        psfl_pkg::PSFL_LATCHED: state_r <= psfl_pkg::PSFL_LATCHED;
        default: state_r <= psfl_pkg::PSFL_OFF;
      endcase
    end
  end

  // Bus soft-start node model: fast step, slow ramp, slow discharge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_ss_r <= `PSFL_SS_ZERO;
    end else if (state_r == psfl_pkg::PSFL_OFF || state_r == psfl_pkg::PSFL_LATCHED) begin
      bus_ss_r <= `PSFL_SS_ZERO;
    end else if (state_r == psfl_pkg::PSFL_RETRY) begin
      // Recurring trip keeps ramping to the charged level first
      if (oc_pend_r && !bus_up && tick) bus_ss_r <= bus_ss_r + 12'h001;
      else if (!oc_pend_r && tick && bus_ss_r != `PSFL_SS_ZERO) bus_ss_r <= bus_ss_r - 12'h001;
    end else if (bus_ss_r < `PSFL_SS_STEP_1V) begin
      bus_ss_r <= `PSFL_SS_STEP_1V;
    end else if (tick && bus_ss_r < `PSFL_SS_FULL_4V5) begin
      bus_ss_r <= bus_ss_r + 12'h001;
    end
  end

  // Core soft-start node model
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_ss_r <= `PSFL_SS_ZERO;
    end else if (state_r == psfl_pkg::PSFL_CORE_RMP || state_r == psfl_pkg::PSFL_RUN) begin
      if (tick && core_ss_r < `PSFL_SS_FULL_4V5) core_ss_r <= core_ss_r + 12'h001;
    end else begin
      core_ss_r <= `PSFL_SS_ZERO;
    end
  end

  // Overcurrent latch: pend marks a recurring trip whose bus node must reach the charged level before discharge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_latch_r <= 1'b0;
      oc_pend_r  <= 1'b0;
    end else if (!sup.bias_ok) begin
      oc_latch_r <= 1'b0;
      oc_pend_r  <= 1'b0;
    // Only the first edge of a trip is taken; a held comparator must not re-arm pend
    end else if (oc_event && !oc_latch_r && state_r != psfl_pkg::PSFL_RETRY && state_r != psfl_pkg::PSFL_OFF) begin
      oc_latch_r <= 1'b1;
      oc_pend_r  <= !bus_up && (core_cnt_r != '0 || bus_cnt_r != '0);
    end else if (state_r == psfl_pkg::PSFL_RETRY) begin
      if (oc_pend_r && bus_up) oc_pend_r <= 1'b0;
      else if (!oc_pend_r && bus_ss_r < `PSFL_SS_LOW_0V8) oc_latch_r <= 1'b0;
    end
  end

  // Consecutive fault counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_cnt_r <= '0;
      bus_cnt_r  <= '0;
    end else if (!sup.bias_ok) begin
      core_cnt_r <= '0;
      bus_cnt_r  <= '0;
    end else if (oc_event && !oc_latch_r && state_r != psfl_pkg::PSFL_OFF
                 && state_r != psfl_pkg::PSFL_RETRY) begin
      if (core_oc_q && core_cnt_r != `PSFL_FAULT_LIMIT) core_cnt_r <= core_cnt_r + 2'h1;
      if ((bus_oc_q || agp_uv_q) && bus_cnt_r != `PSFL_FAULT_LIMIT) bus_cnt_r <= bus_cnt_r + 2'h1;
    end else if (state_r == psfl_pkg::PSFL_RUN && !oc_latch_r) begin
      // A trip seen in run counts first; the clear waits for a clean run
      core_cnt_r <= '0;
      bus_cnt_r  <= '0;
    end
  end

  // Fault latch, cleared only when bias goes away
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_r <= 1'b0;
    end else if (!sup.bias_ok) begin
      fault_r <= 1'b0;
    end else if ((sns.core_ov && state_r != psfl_pkg::PSFL_OFF) || chip_uv_q
                 || core_cnt_r == `PSFL_FAULT_LIMIT || bus_cnt_r == `PSFL_FAULT_LIMIT) begin
      fault_r <= 1'b1;
    end
  end

  // Bus power good: set by first core pulse, dropped by undervoltage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vtt_good_r <= 1'b0;
    end else if (sns.bus_uv || !sns.bus_above_1v08 || core_ss_r < `PSFL_SS_VALLEY
                 || state_r == psfl_pkg::PSFL_OFF || state_r == psfl_pkg::PSFL_RETRY) begin
      vtt_good_r <= 1'b0;
    end else if (sw.core_first_pulse) begin
      vtt_good_r <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_en       <= 1'b0;
      bus_en        <= 1'b0;
      agp_en        <= 1'b0;
      bus_ss_fast   <= 1'b0;
      bus_ss_dis    <= 1'b0;
      core_ss_dis   <= 1'b0;
      bus_ss_level  <= `PSFL_SS_ZERO;
      core_ss_level <= `PSFL_SS_ZERO;
      fault_latched <= 1'b0;
    end else begin
      bus_en        <= state_r == psfl_pkg::PSFL_BUS_RMP || state_r == psfl_pkg::PSFL_CORE_RMP
                       || state_r == psfl_pkg::PSFL_RUN;
      core_en       <= (state_r == psfl_pkg::PSFL_CORE_RMP || state_r == psfl_pkg::PSFL_RUN)
                       && core_ss_r >= `PSFL_SS_VALLEY;
      agp_en        <= state_r == psfl_pkg::PSFL_CORE_RMP || state_r == psfl_pkg::PSFL_RUN;
      bus_ss_fast   <= state_r == psfl_pkg::PSFL_BUS_RMP && bus_ss_r < `PSFL_SS_STEP_1V;
      bus_ss_dis    <= state_r == psfl_pkg::PSFL_RETRY && !oc_pend_r;
      core_ss_dis   <= !(state_r == psfl_pkg::PSFL_CORE_RMP || state_r == psfl_pkg::PSFL_RUN);
      bus_ss_level  <= bus_ss_r;
      core_ss_level <= core_ss_r;
      fault_latched <= fault_r;
    end
  end

  // Chipset linear runs from reset on, independent of supply qualification
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chipset_en <= 1'b0;
    end else begin
      chipset_en <= 1'b1;
    end
  end

  // Early overvoltage clamp before bias qualifies
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_lower_on <= 1'b0;
    end else begin
      core_lower_on <= (!sup.bias_ok && sup.bias_above_4v && sns.core_ov_1v3)
                       || (sns.core_ov && state_r != psfl_pkg::PSFL_OFF);
    end
  end

  // Power good outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_supply_good_out    <= 1'b0;
      system_supply_good_out <= 1'b0;
    end else begin
      bus_supply_good_out    <= vtt_good_r;
      system_supply_good_out <= state_r == psfl_pkg::PSFL_RUN && vtt_good_r && sns.core_in_window
                                && !sns.agp_uv && !sns.chipset_uv;
    end
  end

  chk_ov_latch: assert property (@(posedge clk) disable iff (!nrst)
    sns.core_ov && sup.bias_ok && state_r != psfl_pkg::PSFL_OFF |=> ##1 fault_latched)
    else $error("overvoltage did not latch off");
  chk_chip_uv: assert property (@(posedge clk) disable iff (!nrst)
    chip_uv_q && sup.bias_ok |=> fault_r)
    else $error("chipset undervoltage did not latch");
  chk_core_hold: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_BUS_RMP |-> core_ss_r == `PSFL_SS_ZERO)
    else $error("core node moved before bus good");
  chk_core_valley: assert property (@(posedge clk) disable iff (!nrst)
    core_en |-> $past(core_ss_r) >= `PSFL_SS_VALLEY)
    else $error("core enabled below valley");
  chk_sys_good: assert property (@(posedge clk) disable iff (!nrst)
    system_supply_good_out |-> $past(state_r) == psfl_pkg::PSFL_RUN)
    else $error("system good outside run");
  chk_cnt_limit: assert property (@(posedge clk) disable iff (!nrst)
    (bus_cnt_r == `PSFL_FAULT_LIMIT || core_cnt_r == `PSFL_FAULT_LIMIT) && sup.bias_ok |=> fault_r)
    else $error("three faults did not latch");
  chk_no_start: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_OFF && !por_ok |=> state_r != psfl_pkg::PSFL_BUS_RMP)
    else $error("start without supplies");
  chk_oc_shut: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_RETRY |=> !bus_en && !core_en)
    else $error("outputs on during retry");
  chk_bus_pg_low: assert property (@(posedge clk) disable iff (!nrst)
    sns.bus_uv |=> ##1 !bus_supply_good_out)
    else $error("bus good high under undervoltage");
  // Counting, blanking, bus good, lower clamp, bus step and retry checks
  chk_fault_count: assert property (@(posedge clk) disable iff (!nrst)
    !oc_latch_r && sup.bias_ok && (bus_oc_q || agp_uv_q) && bus_cnt_r != `PSFL_FAULT_LIMIT
    && (state_r == psfl_pkg::PSFL_BUS_RMP || state_r == psfl_pkg::PSFL_CORE_RMP || state_r == psfl_pkg::PSFL_RUN)
    |=> bus_cnt_r == $past(bus_cnt_r) + 2'h1)
    else $error("bus fault not counted");
  chk_uv_blank: assert property (@(posedge clk) disable iff (!nrst)
    sns.chipset_uv && !bus_up && !sns.core_ov && !fault_r
    && core_cnt_r != `PSFL_FAULT_LIMIT && bus_cnt_r != `PSFL_FAULT_LIMIT |=> !fault_r)
    else $error("chipset sag not blanked");
  chk_vtt_set: assert property (@(posedge clk) disable iff (!nrst)
    sw.core_first_pulse && !sns.bus_uv && sns.bus_above_1v08 && core_ss_r >= `PSFL_SS_VALLEY
    && state_r != psfl_pkg::PSFL_OFF && state_r != psfl_pkg::PSFL_RETRY |=> ##1 bus_supply_good_out)
    else $error("bus good not set by core pulse");
  chk_lower_clamp: assert property (@(posedge clk) disable iff (!nrst)
    !sup.bias_ok && sup.bias_above_4v && sns.core_ov_1v3 |=> core_lower_on)
    else $error("core lower switch not forced");
  chk_bus_step: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_BUS_RMP && bus_ss_r < `PSFL_SS_STEP_1V |=> bus_ss_r == `PSFL_SS_STEP_1V)
    else $error("bus node not stepped");
  chk_recur_ramp: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_RETRY && oc_pend_r |=> bus_ss_r >= $past(bus_ss_r))
    else $error("bus node fell before charged");
  chk_latch_clear: assert property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_RETRY && !oc_pend_r && bus_ss_r < `PSFL_SS_LOW_0V8 |=> !oc_latch_r)
    else $error("overcurrent latch not cleared");
  cov_recur: cover property (@(posedge clk) disable iff (!nrst) state_r == psfl_pkg::PSFL_RETRY && oc_pend_r);
  cov_ov_latch: cover property (@(posedge clk) disable iff (!nrst) fault_r && sns.core_ov);
  cov_run: cover property (@(posedge clk) disable iff (!nrst) state_r == psfl_pkg::PSFL_RUN);
  cov_retry: cover property (@(posedge clk) disable iff (!nrst)
    state_r == psfl_pkg::PSFL_RETRY ##1 state_r == psfl_pkg::PSFL_OFF);
  cov_latch: cover property (@(posedge clk) disable iff (!nrst) state_r == psfl_pkg::PSFL_LATCHED);
endmodule : psfl_sequencer

// *** hw/psfl_defs.svh ***
// Timing and threshold constants for the power sequencing fault logic
`ifndef PSFL_DEFS_SVH
`define PSFL_DEFS_SVH
`define PSFL_CLK_MHZ        50
`define PSFL_FAULT_LIMIT    2'h3
`define PSFL_CNT_W          2
`define PSFL_SS_W           12
`define PSFL_SS_ZERO        12'h000
`define PSFL_SS_STEP_1V     12'h2D5
`define PSFL_SS_UP_4V       12'hB5F
`define PSFL_SS_FULL_4V5    12'hCC3
`define PSFL_SS_VALLEY      12'h38D
`define PSFL_SS_LOW_0V8     12'h244
`define PSFL_RAMP_DIV_US    1
`define PSFL_RAMP_DIV       (`PSFL_RAMP_DIV_US * `PSFL_CLK_MHZ)
`endif

// *** hw/psfl_pkg.sv ***
// Types for the power sequencing fault logic
package psfl_pkg;
  typedef enum logic [2:0] {
    PSFL_OFF     = 3'h0,
    PSFL_BUS_RMP = 3'h1,
    PSFL_CORE_RMP= 3'h3,
    PSFL_RUN     = 3'h2,
    PSFL_RETRY   = 3'h6,
    PSFL_LATCHED = 3'h7
  } psfl_state_t;

  typedef struct packed {
    logic bias_ok;
    logic five_ok;
    logic aux_ok;
    logic bias_above_4v;
  } psfl_supply_t;

  typedef struct packed {
    logic core_ov;
    logic core_ov_1v3;
    logic core_in_window;
    logic bus_uv;
    logic bus_above_1v08;
    logic bus_pg90;
    logic agp_uv;
    logic chipset_uv;
  } psfl_sense_t;

  typedef struct packed {
    logic core_oc;
    logic bus_oc;
    logic core_hi_drive;
    logic bus_hi_drive;
    logic core_first_pulse;
  } psfl_switch_t;
endpackage : psfl_pkg

// *** sim/psfl_stage_model.sv ***
// Behavioural power stages, rails and sense comparators facing the sequencer
`timescale 1ns/1ps
module psfl_stage_model #(
  parameter logic [11:0] BUS_GOOD_CODE = 12'h400,
  parameter logic [11:0] CORE_WIN_CODE = 12'hB00
) (
  input  wire logic                   core_en,       // Core switcher enable
  input  wire logic                   bus_en,        // Bus switcher enable
  input  wire logic [11:0]            bus_ss_level,  // Bus node level
  input  wire logic [11:0]            core_ss_level, // Core node level
  input  wire logic                   inj_core_oc,   // Core overload request
  input  wire logic                   inj_bus_oc,    // Bus overload request
  input  wire logic                   inj_agp_uv,    // AGP rail sag request
  input  wire logic                   inj_chip_uv,   // Chipset rail sag request
  input  wire logic                   inj_ov,        // Core overvoltage request
  input  wire logic                   ov_1v3,        // Core sense above 1.3V
  input  wire logic                   mask_hd,       // Hide upper drive activity
  output psfl_pkg::psfl_sense_t       sense,         // Sense comparators
  output psfl_pkg::psfl_switch_t      sw             // Switch status
);
  logic bus_good;

  // Bus rail follows its soft-start clamp once switching
  assign bus_good = bus_en & (bus_ss_level >= BUS_GOOD_CODE);

  always_comb begin
    sense.core_ov        = inj_ov;
    sense.core_ov_1v3    = ov_1v3 | inj_ov;
    sense.core_in_window = core_en & (core_ss_level >= CORE_WIN_CODE);
    sense.bus_uv         = ~bus_good;
    sense.bus_above_1v08 = bus_good;
    sense.bus_pg90       = bus_good;
    sense.agp_uv         = inj_agp_uv;
    sense.chipset_uv     = inj_chip_uv;
    // Overload only shows up while the stage is switching
    sw.core_oc           = inj_core_oc & core_en;
    sw.bus_oc            = inj_bus_oc & bus_en;
    sw.core_hi_drive     = core_en & ~mask_hd;
    sw.bus_hi_drive      = bus_en & ~mask_hd;
    sw.core_first_pulse  = core_en;
  end
endmodule : psfl_stage_model

// *** sim/psfl_sequencer_test.sv ***
// Self-checking bench for the power sequencing fault logic
`timescale 1ns/1ps
`include "psfl_defs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module psfl_sequencer_test;
  localparam int W_BUS = 0, W_CORE = 1, W_BGOOD = 2, W_SGOOD = 3, W_LATCH = 4, W_LOWER = 5;
  logic                   clk, nrst, bus_node_low;
  psfl_pkg::psfl_supply_t supply_in;
  psfl_pkg::psfl_sense_t  sense_in;
  psfl_pkg::psfl_switch_t switch_in;
  logic                   core_en, bus_en, agp_en, chipset_en, core_lower_on;
  logic                   bus_ss_fast, bus_ss_dis, core_ss_dis;
  logic [`PSFL_SS_W-1:0]  bus_ss_level, core_ss_level;
  logic                   bus_supply_good_out, system_supply_good_out, fault_latched;
  logic                   inj_core_oc, inj_bus_oc, inj_agp_uv, inj_chip_uv, inj_ov, ov_1v3, mask_hd;
  int                     n_errors, total_checks;
  int                     n_starts = 0;
  int                     n_mark;
  logic                   bus_en_q;

  // Short ramp step keeps each start-up to a few thousand cycles
  psfl_sequencer #(.RAMP_DIV(1)) i_psfl_sequencer (.clk(clk), .nrst(nrst), .supply_in(supply_in),
    .sense_in(sense_in), .switch_in(switch_in), .bus_node_low(bus_node_low), .core_en(core_en),
    .bus_en(bus_en), .agp_en(agp_en), .chipset_en(chipset_en), .core_lower_on(core_lower_on),
    .bus_ss_fast(bus_ss_fast), .bus_ss_dis(bus_ss_dis), .core_ss_dis(core_ss_dis),
    .bus_ss_level(bus_ss_level), .core_ss_level(core_ss_level), .bus_supply_good_out(bus_supply_good_out),
    .system_supply_good_out(system_supply_good_out), .fault_latched(fault_latched));

  psfl_stage_model i_psfl_stage_model (.core_en(core_en), .bus_en(bus_en), .bus_ss_level(bus_ss_level),
    .core_ss_level(core_ss_level), .inj_core_oc(inj_core_oc), .inj_bus_oc(inj_bus_oc),
    .inj_agp_uv(inj_agp_uv), .inj_chip_uv(inj_chip_uv), .inj_ov(inj_ov), .ov_1v3(ov_1v3),
    .mask_hd(mask_hd), .sense(sense_in), .sw(switch_in));

  always #10 clk = ~clk;

  // Restart count, sampled on the falling edge where outputs are settled
  always @(negedge clk) begin
    bus_en_q <= bus_en;
    if (bus_en && !bus_en_q) n_starts++;
  end

  function automatic logic pick(input int w);
    case (w)
      W_BUS:   return bus_en;
      W_CORE:  return core_en;
      W_BGOOD: return bus_supply_good_out;
      W_SGOOD: return system_supply_good_out;
      W_LATCH: return fault_latched;
      default: return core_lower_on;
    endcase
  endfunction : pick

  task automatic wait_for(input int w, input logic v, input int lim, input string nm);
    int k;
    k = 0;
    while (pick(w) !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    `CHK(nm, v, pick(w))
  endtask : wait_for

  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic bus_trip;
    inj_bus_oc = 1'b1;
    wait_for(W_BUS, 1'b0, 20, "bus_en on trip");
    inj_bus_oc = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("core_en on trip", 1'b0, core_en)
    `CHK("agp_en on trip", 1'b0, agp_en)
    `CHK("core_ss_dis", 1'b1, core_ss_dis)
    `CHK("bus_ss_dis", 1'b1, bus_ss_dis)
    wait_for(W_SGOOD, 1'b1, 20000, "restart good");
  endtask : bus_trip

  task automatic power_cycle;
    supply_in.bias_ok = 1'b0;
    repeat (10) @(negedge clk);
    `CHK("latch after bias loss", 1'b0, fault_latched)
    supply_in.bias_ok = 1'b1;
    wait_for(W_SGOOD, 1'b1, 20000, "good after bias return");
  endtask : power_cycle

  initial begin
    clk = 1'b0; nrst = 1'b0; bus_node_low = 1'b0; supply_in = '0;
    inj_core_oc = 1'b0; inj_bus_oc = 1'b0; inj_agp_uv = 1'b0; inj_chip_uv = 1'b0;
    inj_ov = 1'b0; ov_1v3 = 1'b0; mask_hd = 1'b0; n_errors = 0; total_checks = 0;
    repeat (16) @(negedge clk);
    `CHK("bus_en in reset", 1'b0, bus_en)
    nrst = 1'b1;
    supply_in = '{bias_ok: 1'b0, five_ok: 1'b1, aux_ok: 1'b1, bias_above_4v: 1'b1};
    ov_1v3 = 1'b1;
    wait_for(W_LOWER, 1'b1, 20, "core_lower_on");
    `CHK("chipset_en early", 1'b1, chipset_en)
    ov_1v3 = 1'b0;
    supply_in.bias_ok = 1'b1;
    supply_in.aux_ok = 1'b0;
    repeat (30) @(negedge clk);
    `CHK("bus_en one supply low", 1'b0, bus_en)
    `CHK("bus node held", `PSFL_SS_ZERO, bus_ss_level)
    inj_chip_uv = 1'b1;
    supply_in.aux_ok = 1'b1;
    wait_for(W_BUS, 1'b1, 20, "bus_en start");
    `CHK("bus node fast step", 1'b1, bus_ss_fast)
    `CHK("core node held", `PSFL_SS_ZERO, core_ss_level)
    `CHK("bus good early", 1'b0, bus_supply_good_out)
    repeat (2) @(negedge clk);
    `CHK("bus node step", 1'b1, bus_ss_level >= `PSFL_SS_STEP_1V)
    `CHK("bus node below 4V", 1'b1, bus_ss_level < `PSFL_SS_UP_4V)
    repeat (200) @(negedge clk);
    inj_chip_uv = 1'b0;
    `CHK("blanked chipset sag", 1'b0, fault_latched)
    wait_for(W_CORE, 1'b1, 8000, "core_en");
    `CHK("core node at valley", 1'b1, core_ss_level >= `PSFL_SS_VALLEY)
    wait_for(W_BGOOD, 1'b1, 20, "bus good");
    wait_for(W_SGOOD, 1'b1, 8000, "system good");
    `CHK("agp_en at good", 1'b1, agp_en)
    mask_hd = 1'b1; inj_bus_oc = 1'b1; inj_core_oc = 1'b1;
    repeat (30) @(negedge clk);
    `CHK("masked overload", 1'b1, bus_en)
    inj_core_oc = 1'b0; mask_hd = 1'b0;
    bus_trip();
    bus_trip();
    bus_trip();
    `CHK("counter cleared by run", 1'b0, fault_latched)
    inj_agp_uv = 1'b1;
    wait_for(W_BUS, 1'b0, 20, "agp sag trip");
    inj_agp_uv = 1'b0;
    wait_for(W_SGOOD, 1'b1, 20000, "agp restart");
    bus_node_low = 1'b1;
    wait_for(W_BUS, 1'b0, 20, "node pulled low");
    repeat (2) @(negedge clk);
    `CHK("agp_en node low", 1'b0, agp_en)
    bus_node_low = 1'b0;
    wait_for(W_SGOOD, 1'b1, 20000, "node release");
    n_mark = n_starts;
    inj_bus_oc = 1'b1;
    wait_for(W_LATCH, 1'b1, 40000, "latch third trip");
    `CHK("restarts before latch", 2, n_starts - n_mark)
    inj_bus_oc = 1'b0;
    repeat (100) @(negedge clk);
    `CHK("bus_en latched", 1'b0, bus_en)
    `CHK("latch holds", 1'b1, fault_latched)
    power_cycle();
    inj_ov = 1'b1;
    wait_for(W_LATCH, 1'b1, 20, "overvoltage latch");
    wait_for(W_CORE, 1'b0, 10, "core_en overvoltage");
    repeat (2) @(negedge clk);
    `CHK("bus_en overvoltage", 1'b0, bus_en)
    `CHK("agp_en overvoltage", 1'b0, agp_en)
    inj_ov = 1'b0;
    power_cycle();
    inj_chip_uv = 1'b1;
    wait_for(W_LATCH, 1'b1, 20, "chipset sag latch");
    wait_for(W_BUS, 1'b0, 20, "bus_en chipset sag");
    wrap_up();
  end

  // Expected run is near 45k cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("wrong value watchdog expected done seen hang");
    wrap_up();
  end
endmodule : psfl_sequencer_test
